// [rtl/itmr_pkg.sv]
// Function
// RQ1 - Interval mode runs only when the mode field reads 000.
// RQ2 - Compare-match interrupts occur only while the run bit is one.
// RQ3 - On start the counter goes FFFFH to 0000H at a count edge.
// RQ4 - Count start inverts the primary output pin.
// RQ5 - Count start copies compare value 0 into the match buffer.
// RQ6 - Match clears counter, inverts primary pin, raises match interrupt.
// RQ7 - Interval equals compare value plus one count clock periods.
// RQ8 - Primary pin gives a square wave, half period equals interval.
// RQ9 - Software normally leaves compare channels 1 to 3 unused.
// RQ10 - Per pin enable bit: 0 disables timer drive, 1 enables it.
// RQ11 - Per pin level bit sets disabled pin level: 0 low, 1 high.
// RQ12 - Compare value 0000H matches every count edge from the second.
// RQ13 - Match wrap from FFFFH raises no overflow interrupt or flag.
// RQ14 - Clearing the run bit stops counting and restores FFFFH.
package itmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COMPARE0 = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_OUT_CTRL = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int POS_RUN_BIT = 7;
  localparam int POS_IRQ_MATCH0 = 0;
  localparam int POS_IRQ_OVERFLOW = 1;
  localparam int NUM_IRQ = 2;
  localparam int NUM_PINS = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Values
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [15:0] COUNT_IDLE = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [15:0] RST_COMPARE0 = 16'h0000;
  localparam logic [7:0] RST_OUT_CTRL = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Counter sequencing states
  typedef enum logic [2:0]
  {
    ST_STOP = 3'b001,
    ST_ARMED = 3'b010,
    ST_COUNT = 3'b100
  } itmr_state_t;

endpackage : itmr_pkg

// [rtl/itmr_sync.sv]
`timescale 1ns/1ps
module itmr_sync
  import itmr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous input and its rising edge
  input wire logic async_in,
  output logic rise
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic level;

  ////////////////////////////////////////////////////////////////////////////
  // Three flop chain
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accepted level changes only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level <= 1'b0;
    else if (stage2 == stage3)
      level <= stage3;
  end

  // One cycle pulse on an accepted rise
  assign rise = stage2 & stage3 & ~level;

endmodule : itmr_sync

// [rtl/itmr_timer.sv]
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module itmr_timer
  import itmr_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Count clock from outside
  input wire logic count_clk,
  // Timer output pins
  output logic [3:0] timer_out_pin,
  // Interrupts
  output logic match0_irq,
  output logic overflow_irq,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  itmr_state_t state;
  itmr_state_t next_state;
  logic [7:0] timer_control_0;
  logic [15:0] compare0_value;
  logic [15:0] compare0_buffer;
  logic [15:0] count;
  logic [7:0] timer_output_control;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic [1:0] irq_set;
  logic [3:0] out_toggle;
  logic tick;
  logic run_bit;
  logic mode_ok;
  logic cnt_live;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic start_hit;
  logic match_hit;
  logic wrap_hit;
  logic [31:0] next_prdata;

  // Address match on a word offset
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // Pin level: timer drive when enabled, idle level otherwise
  function automatic logic pin_level(input logic en, input logic lvl,
                                     input logic tog);
    pin_level = en ? tog : lvl;
  endfunction : pin_level

  ////////////////////////////////////////////////////////////////////////////
  // Count clock synchroniser
  itmr_sync u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(count_clk),
    .rise(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign addr_ok = reg_hit(paddr, OFS_CONTROL) | reg_hit(paddr, OFS_COMPARE0)
    | reg_hit(paddr, OFS_COUNT) | reg_hit(paddr, OFS_OUT_CTRL)
    | reg_hit(paddr, OFS_IRQ_STATUS) | reg_hit(paddr, OFS_IRQ_ENABLE)
    | reg_hit(paddr, OFS_IRQ_CLEAR);
  assign pslverr = psel & penable & ~addr_ok;

  // Read mux
  always_comb
  begin
    next_prdata = 32'h00000000;
    case (paddr)
      OFS_CONTROL: next_prdata = {24'h000000, timer_control_0};
      OFS_COMPARE0: next_prdata = {16'h0000, compare0_value};
      OFS_COUNT: next_prdata = {16'h0000, count};
      OFS_OUT_CTRL: next_prdata = {24'h000000, timer_output_control};
      OFS_IRQ_STATUS: next_prdata = {30'h00000000, irq_status};
      OFS_IRQ_ENABLE: next_prdata = {30'h00000000, irq_enable};
      default: next_prdata = 32'h00000000;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_en)
      prdata <= next_prdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_control_0 <= RST_CONTROL;
    else if (wr_en && reg_hit(paddr, OFS_CONTROL))
      timer_control_0 <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare0_value <= RST_COMPARE0;
    else if (wr_en && reg_hit(paddr, OFS_COMPARE0))
      compare0_value <= pwdata[15:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_output_control <= RST_OUT_CTRL;
    else if (wr_en && reg_hit(paddr, OFS_OUT_CTRL))
      timer_output_control <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_enable <= RST_IRQ;
    else if (wr_en && reg_hit(paddr, OFS_IRQ_ENABLE))
      irq_enable <= pwdata[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run and mode decode
  assign run_bit = timer_control_0[POS_RUN_BIT];
  assign mode_ok = (timer_control_0[2:0] == MODE_INTERVAL); // RQ1

  // Count events, gated so a dropped run bit stops them in that same cycle
  assign cnt_live = run_bit && mode_ok; // RQ2
  assign start_hit = (state == ST_ARMED) && tick && cnt_live; // RQ3
  assign match_hit = (state == ST_COUNT) && tick && cnt_live
    && (count == compare0_buffer); // RQ6
  assign wrap_hit = (state == ST_COUNT) && tick && cnt_live && !match_hit
    && (count == COUNT_IDLE); // RQ13

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      ST_STOP:
        if (run_bit && mode_ok)
          next_state = ST_ARMED;
      ST_ARMED:
        if (!run_bit || !mode_ok)
          next_state = ST_STOP; // RQ14
        else if (tick)
          next_state = ST_COUNT;
      ST_COUNT:
        if (!run_bit || !mode_ok)
          next_state = ST_STOP; // RQ14
      default:
        next_state = ST_STOP;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_STOP;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter: idles at FFFFH, clears on start and on match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= COUNT_IDLE;
    else if (next_state == ST_STOP)
      count <= COUNT_IDLE; // RQ14
    else if (start_hit || match_hit)
      count <= COUNT_ZERO; // RQ3 RQ6 RQ7 RQ12
    else if (state == ST_COUNT && tick)
      count <= count + 16'h0001;
  end

  // Compare buffer: loaded at start, follows writes while counting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare0_buffer <= RST_COMPARE0;
    else if (start_hit)
      compare0_buffer <= compare0_value; // RQ5
    else if (state == ST_COUNT)
      compare0_buffer <= compare0_value;
  end

  // Primary pin toggle; others keep idle level, channels 1-3 unused
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_toggle <= 4'h0;
    else
    begin
      if (state == ST_STOP)
        out_toggle[0] <= timer_output_control[1];
      else if (start_hit || match_hit)
        out_toggle[0] <= ~out_toggle[0]; // RQ4 RQ6 RQ8
      out_toggle[3:1] <= {timer_output_control[7], timer_output_control[5],
                          timer_output_control[3]}; // RQ9
    end
  end

  // Registered pins, enable bits even, level bits odd
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_out_pin <= 4'h0;
    else
      for (int k = 0; k < NUM_PINS; k++)
        timer_out_pin[k] <= pin_level(timer_output_control[2*k],
          timer_output_control[2*k+1], out_toggle[k]); // RQ10 RQ11
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match0_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end
    else
    begin
      match0_irq <= match_hit; // RQ2 RQ6
      overflow_irq <= wrap_hit; // RQ13
    end
  end

  // Sticky status, set wins over clear
  assign irq_set = {wrap_hit, match_hit};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= RST_IRQ;
    else if (wr_en && reg_hit(paddr, OFS_IRQ_CLEAR))
      irq_status <= (irq_status & ~pwdata[1:0]) | irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  assign irq = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_start;
    (state == ST_ARMED) && tick && run_bit && mode_ok;
  endsequence

  sequence s_match;
    (state == ST_COUNT) && tick && run_bit && mode_ok
      && (count == compare0_buffer);
  endsequence

  sequence s_step;
    (state == ST_COUNT) && tick && run_bit && mode_ok
      && (count != compare0_buffer);
  endsequence

  sequence s_wait;
    (state == ST_COUNT) && !tick && run_bit && mode_ok;
  endsequence

  a_mode_gate: assert property (!mode_ok |=> state == ST_STOP) // RQ1
    else $error("timer left stopped state outside interval mode");

  a_irq_needs_run: assert property (match0_irq |-> $past(run_bit)) // RQ2
    else $error("match interrupt without run bit");

  a_start_clear: assert property (s_start |=> count == COUNT_ZERO // RQ3
    && state == ST_COUNT)
    else $error("counter not cleared at count start");

  a_start_toggle: assert property (s_start |=> // RQ4
    out_toggle[0] != $past(out_toggle[0]))
    else $error("primary output not inverted at start");

  a_start_load: assert property (s_start |=> // RQ5
    compare0_buffer == $past(compare0_value))
    else $error("compare buffer not loaded at start");

  a_match_effect: assert property (s_match |=> count == COUNT_ZERO // RQ6
    && match0_irq && irq_status[POS_IRQ_MATCH0]
    && out_toggle[0] != $past(out_toggle[0]))
    else $error("match did not clear, toggle and flag");

  a_zero_repeat: assert property ((state == ST_COUNT) && run_bit // RQ12
    && mode_ok && compare0_buffer == COUNT_ZERO && count == COUNT_ZERO
    && tick |=> count == COUNT_ZERO && match0_irq)
    else $error("zero compare did not match every edge");

  a_wrap_no_ovf: assert property (s_match ##0 (count == COUNT_IDLE) // RQ13
    |=> !overflow_irq)
    else $error("overflow raised on match wrap");

  a_stop_idle: assert property (!run_bit |=> count == COUNT_IDLE // RQ14
    && state == ST_STOP)
    else $error("counter not idle after run cleared");

  a_pin_idle: assert property (!timer_output_control[0] // RQ11
    |=> timer_out_pin[0] == $past(timer_output_control[1]))
    else $error("disabled pin not at idle level");

  a_count_step: assert property (s_step |=> // RQ7
    count == $past(count) + 16'h0001)
    else $error("counter did not advance by one");

  a_count_hold: assert property (s_wait |=> // RQ7
    count == $past(count))
    else $error("counter moved without a count edge");

  a_square_half: assert property (s_step |=> // RQ8
    out_toggle[0] == $past(out_toggle[0]))
    else $error("primary output changed between matches");

  a_pin_drive: assert property (timer_output_control[0] |=> // RQ10
    timer_out_pin[0] == $past(out_toggle[0]))
    else $error("enabled pin does not follow timer output");

endmodule : itmr_timer

// [test/tb_interval_timer_mode.sv]
`timescale 1ns/1ps
module tb_interval_timer_mode
  import itmr_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  // Design signals and bench state
  logic pclk, presetn, psel, penable, pwrite, count_clk;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic pready, pslverr, match0_irq, overflow_irq, irq, er;
  logic [3:0] timer_out_pin;
  int n_mismatch, n_compared, cyc, n_pulse, n_ovf, seed_v;
  int m_cnt, cmp, m_match, oc, p0, tr, k;
  bit running, started, tog;

  itmr_timer itmr_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_clk(count_clk), .timer_out_pin(timer_out_pin),
    .match0_irq(match0_irq), .overflow_irq(overflow_irq), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, pulse monitor and hang guard
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (match0_irq === 1'b1) n_pulse++;
    if (overflow_irq === 1'b1) n_ovf++;
    if (cyc >= 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task end_of_test;
    $display("compared %0d mismatch %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_v = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", e, rd_v);
    chk("pslverr", 32'h0, {31'h0, er});
  endtask : rd

  // One count clock period, then the reference model steps
  task tick;
    count_clk <= 1'b1;
    repeat (4) @(posedge pclk);
    count_clk <= 1'b0;
    repeat (4) @(posedge pclk);
    if (running && !started)
    begin
      started = 1;
      m_cnt = 0;
      tog = !tog;
    end
    else if (running && m_cnt == cmp)
    begin
      m_cnt = 0;
      tog = !tog;
      m_match++;
    end
    else if (running)
      m_cnt = (m_cnt + 1) & 16'hFFFF;
  endtask : tick

  // Pins settle two edges after a control write, toggle flop then pin flop
  task pins;
    repeat (3) @(posedge pclk);
    p0 = (oc & 1) ? int'(tog) : (oc >> 1) & 1;
    chk("pins", {28'h0, oc[7], oc[5], oc[3], p0[0]}, timer_out_pin);
  endtask : pins

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, count_clk} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    seed_v = $urandom(41398);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CONTROL, 32'h0000_0000);
    rd(OFS_OUT_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_COUNT, 32'h0000_1234);
    rd(OFS_COUNT, 32'h0000_FFFF);
    apb(1'b1, 8'h1C, 32'h0000_00FF);
    chk("unmapped err", 32'h1, {31'h0, er});
    rd(OFS_IRQ_CLEAR, 32'h0000_0000);
    // Run with compare value 0 first, then small random ones, pin 0 disabled on the last
    for (tr = 0; tr < 3; tr++)
    begin
      cmp = (tr == 0) ? 0 : $urandom % 5;
      oc = $urandom % 256;
      oc = (tr == 2) ? (oc & 8'hFE) : (oc | 1);
      tog = (oc >> 1) & 1;
      m_match = 0;
      k = n_pulse;
      apb(1'b1, OFS_OUT_CTRL, oc);
      pins();
      apb(1'b1, OFS_COMPARE0, cmp);
      apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0001);
      apb(1'b1, OFS_CONTROL, 32'h0000_0080);
      running = 1;
      started = 0;
      repeat (3 * (cmp + 1) + 2)
      begin
        tick();
        rd(OFS_COUNT, m_cnt);
        pins();
      end
      chk("match pulses", m_match, n_pulse - k);
      rd(OFS_IRQ_STATUS, 32'h0000_0001);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0000);
      @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, OFS_CONTROL, 32'h0000_0000);
      running = 0;
      tog = (oc >> 1) & 1;
      k = n_pulse;
      tick();
      rd(OFS_COUNT, 32'h0000_FFFF);
      chk("stopped pulses", 32'h0, n_pulse - k);
      apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_0003);
      rd(OFS_IRQ_STATUS, 32'h0000_0000);
    end
    chk("overflow pulses", 32'h0, n_ovf);
    // Other mode codes never count
    for (tr = 1; tr < 8; tr++)
    begin
      apb(1'b1, OFS_CONTROL, 32'h0000_0080 | tr);
      tick();
      tick();
      rd(OFS_COUNT, 32'h0000_FFFF);
    end
    end_of_test();
  end

endmodule : tb_interval_timer_mode
